// ---- core/panel_bus_master.sv ----
`timescale 1ns/1ps
module panel_bus_master (
  input  wire logic       clk_sys_i,              // System clock, 250 MHz
  input  wire logic       rstn_i,                 // Sync reset, active low
  input  wire logic       init_req_i,             // Request panel init pulse
  input  wire logic [1:0] req_op_i,               // Operation code
  input  wire logic [7:0] req_data_i,             // Write byte
  input  wire logic       req_valid_i,            // Request present
  output logic            req_ready_o,            // Request accepted
  output logic [7:0]      rsp_data_o,             // Read byte
  output logic            rsp_valid_o,            // Read byte present
  input  wire logic       rsp_ready_i,            // Sink takes read byte
  output logic            busy_o,                 // Transfer or init active
  output logic            panel_select_n_o,       // Panel chip select, low
  output logic            cmd_data_select_o,      // Low index/status, high data
  output logic            panel_load_strobe_n_o,  // Read strobe, low
  output logic            panel_store_strobe_n_o, // Write strobe, low
  output logic            panel_init_strobe_n_o,  // Panel reset, low
  input  wire logic [7:0] panel_data_bus_i,       // Bus level from pins
  output logic [7:0]      panel_data_bus_o,       // Bus drive value
  output logic            panel_data_bus_oe_o     // High while driving bus
);
  typedef enum {
    ST_IDLE,
    ST_STORE_LOW,
    ST_STORE_HIGH,
    ST_LOAD_LOW,
    ST_LOAD_HIGH,
    ST_INIT_LOW
  } state_t;

  localparam logic [panel_bus_pkg::CNT_W-1:0] STORE_LOW_N =
    panel_bus_pkg::CNT_W'(panel_bus_pkg::STORE_LOW_CYC);
  localparam logic [panel_bus_pkg::CNT_W-1:0] STORE_HIGH_N =
    panel_bus_pkg::CNT_W'(panel_bus_pkg::STORE_CYCLE_CYC - panel_bus_pkg::STORE_LOW_CYC);
  localparam logic [panel_bus_pkg::CNT_W-1:0] LOAD_LOW_N =
    panel_bus_pkg::CNT_W'(panel_bus_pkg::LOAD_LOW_CYC);
  localparam logic [panel_bus_pkg::CNT_W-1:0] LOAD_HIGH_N =
    panel_bus_pkg::CNT_W'(panel_bus_pkg::LOAD_CYCLE_CYC - panel_bus_pkg::LOAD_LOW_CYC);
  localparam logic [panel_bus_pkg::CNT_W-1:0] INIT_LOW_N =
    panel_bus_pkg::CNT_W'(panel_bus_pkg::INIT_LOW_CYC);

  // Cycle figures must fit the phase counter and cover both halves
  initial
  begin
    if (panel_bus_pkg::INIT_LOW_CYC >= (1 << panel_bus_pkg::CNT_W))
      $error("panel_bus_master: phase counter too narrow");
    // The idle edge before the next fall adds one cycle of high time
    if (panel_bus_pkg::STORE_CYCLE_CYC - panel_bus_pkg::STORE_LOW_CYC + 1
        < panel_bus_pkg::STORE_HIGH_CYC)
      $error("panel_bus_master: store high phase too short");
    if (panel_bus_pkg::LOAD_CYCLE_CYC - panel_bus_pkg::LOAD_LOW_CYC + 1
        < panel_bus_pkg::LOAD_HIGH_CYC)
      $error("panel_bus_master: load high phase too short");
  end

  // Decode helpers, used by the command path and pin drivers
  function automatic logic op_is_write(input logic [1:0] op);
    return op[panel_bus_pkg::OP_WR_BIT];
  endfunction
  function automatic logic op_cmd_level(input logic [1:0] op);
    return op[panel_bus_pkg::OP_SEL_BIT];
  endfunction

  state_t                          state;      // Sequencer state
  logic [panel_bus_pkg::CNT_W-1:0] phase_cnt;  // Cycles left in phase
  logic                            init_pend;  // Init requested, not started

  // Request buffer output side
  logic [9:0] q_word;   // {op, data}
  logic       q_valid;  // Buffered request present
  logic       q_take;   // Sequencer consumes it
  logic [1:0] q_op;     // Buffered op
  logic [7:0] q_data;   // Buffered byte
  assign q_op = q_word[9:8];
  assign q_data = q_word[7:0];

  // Read return buffer input side
  logic       rb_ready;  // Room for a read byte
  logic       rb_push;   // Read byte captured
  logic [7:0] bus_sync;  // Synchronised pins

  // Requests buffered two deep, so the requester is held by a slow bus only once both slots are full
  skid_buffer2 #(
    .WIDTH (10)
  ) u_req_buf (
    .clk_sys_i   (clk_sys_i),
    .rstn_i      (rstn_i),
    .in_data_i   ({req_op_i, req_data_i}),
    .in_valid_i  (req_valid_i),
    .in_ready_o  (req_ready_o),
    .out_data_o  (q_word),
    .out_valid_o (q_valid),
    .out_ready_i (q_take)
  );

  // Pins cross from the panel's timing into ours
  pin_sync2 #(
    .WIDTH (panel_bus_pkg::DATA_W)
  ) u_bus_sync (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .async_i   (panel_data_bus_i),
    .sync_o    (bus_sync)
  );

  // Reads wait for return room, so a stalled sink loses no byte
  assign q_take = (state == ST_IDLE) && !init_pend && q_valid &&
                  (op_is_write(q_op) || rb_ready);

  // Init request latched; set wins over the start clear
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      init_pend <= 1'b0;
    else if (init_req_i)
      init_pend <= 1'b1;
    else if (state == ST_IDLE)
      init_pend <= 1'b0;
  end

  // Sequencer: strobe phases timed by the phase counter
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      state <= ST_IDLE;
      phase_cnt <= panel_bus_pkg::CNT_ZERO;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (init_pend)
          begin
            state <= ST_INIT_LOW;
            phase_cnt <= INIT_LOW_N;
          end
          else if (q_take && op_is_write(q_op))
          begin
            state <= ST_STORE_LOW;
            phase_cnt <= STORE_LOW_N;
          end
          else if (q_take)
          begin
            state <= ST_LOAD_LOW;
            phase_cnt <= LOAD_LOW_N;
          end
        end
        ST_STORE_LOW:
        begin
          if (phase_cnt == panel_bus_pkg::CNT_ONE)
          begin
            state <= ST_STORE_HIGH;
            phase_cnt <= STORE_HIGH_N;
          end
          else
            phase_cnt <= phase_cnt - panel_bus_pkg::CNT_ONE;
        end
        ST_LOAD_LOW:
        begin
          if (phase_cnt == panel_bus_pkg::CNT_ONE)
          begin
            state <= ST_LOAD_HIGH;
            phase_cnt <= LOAD_HIGH_N;
          end
          else
            phase_cnt <= phase_cnt - panel_bus_pkg::CNT_ONE;
        end
        ST_STORE_HIGH, ST_LOAD_HIGH, ST_INIT_LOW:
        begin
          if (phase_cnt == panel_bus_pkg::CNT_ONE)
            state <= ST_IDLE;
          else
            phase_cnt <= phase_cnt - panel_bus_pkg::CNT_ONE;
        end
        default:
        begin
          state <= ST_IDLE;
          phase_cnt <= panel_bus_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  // Pin drivers; select stays low through the high phase too
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      panel_select_n_o <= panel_bus_pkg::STROBE_IDLE;
      cmd_data_select_o <= 1'b0;
      panel_load_strobe_n_o <= panel_bus_pkg::STROBE_IDLE;
      panel_store_strobe_n_o <= panel_bus_pkg::STROBE_IDLE;
      panel_data_bus_o <= 8'h00;
      panel_data_bus_oe_o <= 1'b0;
    end
    else if (state == ST_IDLE && !init_pend && q_take)
    begin
      panel_select_n_o <= panel_bus_pkg::STROBE_ACTIVE;
      cmd_data_select_o <= op_cmd_level(q_op);
      panel_load_strobe_n_o <= op_is_write(q_op);
      panel_store_strobe_n_o <= ~op_is_write(q_op);
      panel_data_bus_o <= q_data;
      panel_data_bus_oe_o <= op_is_write(q_op);
    end
    else if ((state == ST_STORE_LOW || state == ST_LOAD_LOW) &&
             phase_cnt == panel_bus_pkg::CNT_ONE)
    begin
      // Strobes rise; select and data held through the high phase
      panel_load_strobe_n_o <= panel_bus_pkg::STROBE_IDLE;
      panel_store_strobe_n_o <= panel_bus_pkg::STROBE_IDLE;
    end
    else if ((state == ST_STORE_HIGH || state == ST_LOAD_HIGH) &&
             phase_cnt == panel_bus_pkg::CNT_ONE)
    begin
      panel_select_n_o <= panel_bus_pkg::STROBE_IDLE;
      panel_data_bus_oe_o <= 1'b0;
    end
  end

  // Init strobe low for the whole init phase
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      panel_init_strobe_n_o <= panel_bus_pkg::STROBE_IDLE;
    else
      panel_init_strobe_n_o <= !(state == ST_IDLE && init_pend) &&
                               !(state == ST_INIT_LOW && phase_cnt != panel_bus_pkg::CNT_ONE);
  end

  // Sample at end of load low phase; sync delay covered by 75 cycles
  assign rb_push = (state == ST_LOAD_LOW) && (phase_cnt == panel_bus_pkg::CNT_ONE);

  logic [7:0] rb_data;   // Buffer head
  logic       rb_valid;  // Buffer head present

  skid_buffer2 #(
    .WIDTH (panel_bus_pkg::DATA_W)
  ) u_rsp_buf (
    .clk_sys_i   (clk_sys_i),
    .rstn_i      (rstn_i),
    .in_data_i   (bus_sync),
    .in_valid_i  (rb_push),
    .in_ready_o  (rb_ready),
    .out_data_o  (rb_data),
    .out_valid_o (rb_valid),
    .out_ready_i (!rsp_valid_o || rsp_ready_i)
  );

  // Registered read port; reloads only when empty or taken, so valid holds
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
    end
    else if (!rsp_valid_o || rsp_ready_i)
    begin
      rsp_valid_o <= rb_valid;
      rsp_data_o <= rb_data;
    end
  end

  // Busy flag from sequencer state, pending init and buffered request
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      busy_o <= 1'b0;
    else
      busy_o <= (state != ST_IDLE) || init_pend || q_valid;
  end

  // Store or load low phase length, counted from the falling strobe
  logic [panel_bus_pkg::CNT_W-1:0] low_len;  // Cycles strobe low so far
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      low_len <= panel_bus_pkg::CNT_ZERO;
    else if (!panel_store_strobe_n_o || !panel_load_strobe_n_o)
      low_len <= low_len + panel_bus_pkg::CNT_ONE;
    else
      low_len <= panel_bus_pkg::CNT_ZERO;
  end

  // Both strobes high, counted; saturates so a long idle reads as plenty
  logic [panel_bus_pkg::CNT_W-1:0] high_len;  // Cycles both strobes high
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      high_len <= '1;
    else if (!panel_store_strobe_n_o || !panel_load_strobe_n_o)
      high_len <= panel_bus_pkg::CNT_ZERO;
    else if (high_len != '1)
      high_len <= high_len + panel_bus_pkg::CNT_ONE;
  end

  localparam int STORE_LOW_MIN = int'(panel_bus_pkg::STORE_LOW_CYC);   // Exact low phase
  localparam int STORE_HIGH_MIN = int'(panel_bus_pkg::STORE_HIGH_CYC); // Least high time
  localparam int LOAD_LOW_MIN = int'(panel_bus_pkg::LOAD_LOW_CYC);     // Exact low phase

  sequence store_rise_s;
    $rose(panel_store_strobe_n_o);
  endsequence

  chk_no_dual_strobe: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !(!panel_store_strobe_n_o && !panel_load_strobe_n_o))
    else $error("both strobes low");
  chk_store_low_len: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    store_rise_s |-> low_len == 10'(STORE_LOW_MIN))
    else $error("store low time wrong");
  chk_store_high_len: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(panel_store_strobe_n_o) |-> high_len >= 10'(STORE_HIGH_MIN))
    else $error("store high time too short");
  chk_load_low_len: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(panel_load_strobe_n_o) |-> low_len == 10'(LOAD_LOW_MIN))
    else $error("load low time wrong");
  chk_select_gates: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (!panel_store_strobe_n_o || !panel_load_strobe_n_o) |-> !panel_select_n_o)
    else $error("strobe without select");
  chk_bus_release: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !panel_load_strobe_n_o |-> !panel_data_bus_oe_o)
    else $error("bus driven during load");
  chk_data_stable: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (!panel_store_strobe_n_o && $past(!panel_store_strobe_n_o)) |->
      panel_data_bus_oe_o && $stable(panel_data_bus_o))
    else $error("write data moved under strobe");
  chk_init_pulse: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(panel_init_strobe_n_o) |-> !panel_init_strobe_n_o [*8] ##[1:600] panel_init_strobe_n_o)
    else $error("init pulse wrong");
  chk_read_capture: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rb_push |-> !panel_load_strobe_n_o)
    else $error("read sampled without strobe");
endmodule

// ---- shared/panel_bus_pkg.sv ----
package panel_bus_pkg;
  // Clock rate in MHz (250 MHz, 4 ns period)
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Minimum strobe times in ns
  localparam int unsigned STORE_LOW_TIME_NS = 170;
  localparam int unsigned STORE_HIGH_TIME_NS = 85;
  localparam int unsigned STORE_CYCLE_TIME_NS = 255;
  localparam int unsigned STORE_DATA_LEAD_TIME_NS = 85;
  localparam int unsigned LOAD_LOW_TIME_NS = 300;
  localparam int unsigned LOAD_HIGH_TIME_NS = 300;
  localparam int unsigned LOAD_CYCLE_TIME_NS = 600;
  localparam int unsigned INIT_LOW_TIME_NS = 2000;

  // Least times round up to whole cycles
  localparam int unsigned STORE_LOW_CYC = (STORE_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STORE_HIGH_CYC =
    (STORE_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STORE_CYCLE_CYC =
    (STORE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STORE_LEAD_CYC =
    (STORE_DATA_LEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOAD_LOW_CYC = (LOAD_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOAD_HIGH_CYC = (LOAD_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOAD_CYCLE_CYC =
    (LOAD_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_LOW_CYC = (INIT_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter width for phase timing
  localparam int unsigned CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;

  // Data bus width
  localparam int unsigned DATA_W = 8;

  // Operation codes on the request port
  typedef enum logic [1:0] {
    OP_READ_STATUS = 2'h0,  // select low, read
    OP_WRITE_INDEX = 2'h1,  // select low, write
    OP_READ_PIXEL  = 2'h2,  // select high, read
    OP_WRITE_DATA  = 2'h3   // select high, write
  } panel_op_t;

  // Op field positions
  localparam int unsigned OP_SEL_BIT = 1;
  localparam int unsigned OP_WR_BIT = 0;

  // Idle level of every strobe
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic STROBE_ACTIVE = 1'b0;
endpackage

// ---- core/skid_buffer2.sv ----
`timescale 1ns/1ps
// Two-entry buffer; ready depends only on fill level so no
// combinational path runs from sink ready to source ready.
module skid_buffer2 #(
  parameter int unsigned WIDTH = 8  // Word width
) (
  input  wire logic             clk_sys_i,  // System clock
  input  wire logic             rstn_i,     // Sync reset, active low
  input  wire logic [WIDTH-1:0] in_data_i,  // Word from source
  input  wire logic             in_valid_i, // Source has a word
  output logic                  in_ready_o, // Room for a word
  output logic      [WIDTH-1:0] out_data_o, // Oldest word
  output logic                  out_valid_o,// Oldest word present
  input  wire logic             out_ready_i // Sink takes it
);
  initial
  begin
    if (WIDTH < 1)
      $error("skid_buffer2: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mem [2];  // Storage slots
  logic             wr_ptr;   // Next slot to fill
  logic             rd_ptr;   // Next slot to drain
  logic [1:0]       fill;     // Entries held

  logic push;  // Word accepted
  logic pop;   // Word drained
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = (fill != 2'h0);
  assign out_data_o = mem[rd_ptr];

  // Slot storage, no reset needed for data
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  // Pointers, fill count and registered room flag
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill <= 2'h0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      case ({push, pop})
        2'b10:
        begin
          fill <= fill + 2'h1;
          in_ready_o <= (fill != 2'h1);  // Full after this push
        end
        2'b01:
        begin
          fill <= fill - 2'h1;
          in_ready_o <= 1'b1;            // A slot was freed
        end
        default: fill <= fill;
      endcase
    end
  end
endmodule

// ---- core/pin_sync2.sv ----
`timescale 1ns/1ps
// Two-flop synchroniser per bit for the sampled data pins
module pin_sync2 #(
  parameter int unsigned WIDTH = 8  // Bits synchronised
) (
  input  wire logic             clk_sys_i, // System clock
  input  wire logic             rstn_i,    // Sync reset, active low
  input  wire logic [WIDTH-1:0] async_i,   // Pin levels
  output logic      [WIDTH-1:0] sync_o     // Synchronised levels
);
  logic [WIDTH-1:0] meta;  // First stage, read only by second

  // Both stages in one process; meta feeds sync_o only
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      meta <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// ---- testbench/panel_display_model.sv ----
`timescale 1ns/1ps
// Display controller behind the 8-bit parallel bus; no pull on the data
// lines, so a released bus shows the inverse of its last level
module panel_display_model (
  input  wire logic       select_n_i, // Chip select, low
  input  wire logic       cmd_i,      // Low index/status, high data
  input  wire logic       load_n_i,   // Read strobe, low
  input  wire logic       store_n_i,  // Write strobe, low
  input  wire logic       oe_i,       // Master drives the bus
  input  wire logic [7:0] data_i,     // Master drive value
  input  wire logic [7:0] status_i,   // Status byte base
  input  wire logic [7:0] pixel_i,    // Pixel byte base
  input  wire logic       slow_i,     // Late read data
  output logic      [7:0] bus_o,      // Resolved bus level
  output int              viol_o,     // Timing or protocol faults
  output int              wr_cnt_o    // Bytes stored
);
  logic [7:0] wr_data [32]; // Stored bytes in order
  logic       wr_cmd  [32]; // Select level per stored byte
  logic [7:0] rd_val;       // Byte answered on a load
  logic [7:0] last = 8'h00; // Last level driven on the bus
  logic       drv = 1'b0;   // Model drives the bus
  int         rd_cnt = 0;   // Loads answered, varies each answer
  realtime    t_sf = -1.0e6; // Store fall
  realtime    t_sr = -1.0e6; // Store rise
  realtime    t_lf = -1.0e6; // Load fall
  realtime    t_lr = -1.0e6; // Load rise
  realtime    t_d = 0.0;     // Last data change

  initial
  begin
    viol_o = 0;
    wr_cnt_o = 0;
  end

  // Wire level from both parties' enables
  assign bus_o = oe_i ? data_i : (drv ? rd_val : ~last);

  // Data settle time for the lead check
  always @(data_i or oe_i)
  begin
    t_d = $realtime;
    if (oe_i)
      last = data_i;
  end

  // Store strobe falls: high time, cycle, no overlap with load
  always @(negedge store_n_i)
  begin
    if ($realtime - t_sr < 85.0 || $realtime - t_sf < 255.0)
      viol_o++;
    if (load_n_i !== 1'b1 || select_n_i !== 1'b0)
      viol_o++;
    t_sf = $realtime;
  end

  // Store strobe rises: byte latched only while selected
  always @(posedge store_n_i)
  begin
    if (select_n_i === 1'b0)
    begin
      if ($realtime - t_sf < 170.0 || $realtime - t_d < 85.0)
        viol_o++;
      if (oe_i !== 1'b1)
        viol_o++;
      wr_data[wr_cnt_o[4:0]] = data_i;
      wr_cmd[wr_cnt_o[4:0]] = cmd_i;
      wr_cnt_o++;
      t_sr = $realtime;
    end
  end

  // Load strobe falls: answer after a short or long access time
  always @(negedge load_n_i)
  begin
    if (select_n_i !== 1'b0 || oe_i !== 1'b0 || store_n_i !== 1'b1)
      viol_o++;
    if ($realtime - t_lr < 300.0 || $realtime - t_lf < 600.0)
      viol_o++;
    t_lf = $realtime;
    rd_val = (cmd_i ? pixel_i : status_i) ^ rd_cnt[7:0];
    rd_cnt++;
    #(slow_i ? 200.0 : 20.0);
    if (load_n_i === 1'b0)
    begin
      drv = 1'b1;
      last = rd_val;
    end
  end

  // Load strobe rises: low time, then release the bus
  always @(posedge load_n_i)
  begin
    if (select_n_i === 1'b0)
    begin
      if ($realtime - t_lf < 300.0)
        viol_o++;
      t_lr = $realtime;
    end
    drv = 1'b0;
  end

  // Master must not drive into a load
  always @(posedge oe_i)
    if (load_n_i === 1'b0)
      viol_o++;
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic       clk_sys_i = 1'b0;   // System clock
  logic       rstn_i = 1'b0;      // Reset, active low
  logic       init_req_i = 1'b0;  // Init request
  logic [1:0] req_op_i = 2'h0;    // Operation
  logic [7:0] req_data_i = 8'h00; // Write byte
  logic       req_valid_i = 1'b0; // Request valid
  logic       rsp_ready_i = 1'b0; // Sink ready
  logic       slow = 1'b0;        // Late panel answers
  logic       req_ready_o, rsp_valid_o, busy_o, select_n, cmd, load_n, store_n, init_n, oe;
  logic [7:0] rsp_data_o, bus_lvl, bus_drv;
  int         viol, wr_cnt;
  int         error_cnt = 0;      // Mismatches
  int         n_checks = 0;       // Comparisons
  int         rd_k = 0;           // Loads issued so far
  logic       refused;            // Request port pushed back
  logic [7:0] st_val = 8'h3C;     // Status base
  logic [7:0] px_val = 8'hC3;     // Pixel base

  // 250 MHz clock
  always #2 clk_sys_i = ~clk_sys_i;

  panel_bus_master dut_u (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .init_req_i(init_req_i),
    .req_op_i(req_op_i), .req_data_i(req_data_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .rsp_data_o(rsp_data_o), .rsp_valid_o(rsp_valid_o),
    .rsp_ready_i(rsp_ready_i), .busy_o(busy_o), .panel_select_n_o(select_n),
    .cmd_data_select_o(cmd), .panel_load_strobe_n_o(load_n),
    .panel_store_strobe_n_o(store_n), .panel_init_strobe_n_o(init_n),
    .panel_data_bus_i(bus_lvl), .panel_data_bus_o(bus_drv), .panel_data_bus_oe_o(oe));

  panel_display_model model_u (
    .select_n_i(select_n), .cmd_i(cmd), .load_n_i(load_n), .store_n_i(store_n),
    .oe_i(oe), .data_i(bus_drv), .status_i(st_val), .pixel_i(px_val), .slow_i(slow),
    .bus_o(bus_lvl), .viol_o(viol), .wr_cnt_o(wr_cnt));

  // Compare and report
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  // Single place where the run ends
  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Offer one request; valid stays up until the caller moves on
  task automatic send(input logic [1:0] op, input logic [7:0] data);
    int n;
    @(negedge clk_sys_i);
    req_valid_i = 1'b1;
    req_op_i = op;
    req_data_i = data;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 2000)
    begin
      refused = 1'b1;
      @(negedge clk_sys_i);
      n++;
    end
    check("request taken", 8'h01, {7'h00, req_ready_o === 1'b1});
    @(posedge clk_sys_i);
  endtask

  // Drop valid and wait for the sequencer to drain
  task automatic settle();
    int n;
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    n = 0;
    while ((busy_o !== 1'b0 || n < 3) && n < 3000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    check("busy falls", 8'h00, {7'h00, busy_o});
  endtask

  // Take one read byte and compare it
  task automatic take(input logic [7:0] exp);
    int n;
    @(negedge clk_sys_i);
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 3000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    check("read byte", exp, rsp_data_o);
    rsp_ready_i = 1'b1;
    @(negedge clk_sys_i);
    rsp_ready_i = 1'b0;
  endtask

  // Idle levels after reset
  task automatic t_reset();
    check("idle pins", 8'h1F, {3'h0, select_n, load_n, store_n, init_n, ~oe});
    check("idle port", 8'h01, {5'h0, busy_o, rsp_valid_o, req_ready_o});
  endtask

  // Init pulse: low for the chosen span with no access
  task automatic t_init();
    int n;
    @(negedge clk_sys_i);
    init_req_i = 1'b1;
    @(negedge clk_sys_i);
    init_req_i = 1'b0;
    n = 0;
    while (init_n !== 1'b1 || n == 0)
    begin
      if (init_n === 1'b0)
        n++;
      if (n > 3000)
        break;
      check("select during init", 8'h01, {7'h00, select_n});
      @(negedge clk_sys_i);
    end
    check("init low cycles", 8'h01, {7'h00, n >= panel_bus_pkg::INIT_LOW_CYC});
  endtask

  // Index then data write, order and select level kept
  task automatic t_write();
    send(2'h1, 8'hA5);
    send(2'h3, 8'h5A);
    settle();
    check("stored count", 8'h02, wr_cnt[7:0]);
    check("index byte", 8'hA5, model_u.wr_data[0]);
    check("index select", 8'h00, {7'h00, model_u.wr_cmd[0]});
    check("data byte", 8'h5A, model_u.wr_data[1]);
    check("data select", 8'h01, {7'h00, model_u.wr_cmd[1]});
  endtask

  // Status and pixel reads, with prompt and late panel
  task automatic t_read(input logic late);
    slow = late;
    send(2'h0, 8'h00);
    settle();
    take(st_val ^ rd_k[7:0]);
    rd_k++;
    send(2'h2, 8'h00);
    settle();
    take(px_val ^ rd_k[7:0]);
    rd_k++;
  endtask

  // Writes back to back until the buffer refuses
  task automatic t_fill();
    int i;
    refused = 1'b0;
    for (i = 0; i < 4; i++)
      send(2'h3, 8'h10 + i[7:0]);
    settle();
    check("buffer refused", 8'h01, {7'h00, refused});
    for (i = 0; i < 4; i++)
      check("burst byte", 8'h10 + i[7:0], model_u.wr_data[2 + i]);
  endtask

  // Reads queued while the sink stalls; answers wait in order
  task automatic t_stall();
    int n;
    logic [7:0] first;
    send(2'h2, 8'h00);
    send(2'h0, 8'h00);
    send(2'h2, 8'h00);
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 3000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    first = rsp_data_o;
    for (n = 0; n < 400; n++)
    begin
      @(negedge clk_sys_i);
      check("held byte", first, rsp_data_o);
      check("held valid", 8'h01, {7'h00, rsp_valid_o});
    end
    take(px_val ^ rd_k[7:0]);
    take(st_val ^ (rd_k[7:0] + 8'h01));
    take(px_val ^ (rd_k[7:0] + 8'h02));
    rd_k += 3;
    settle();
  endtask

  // Watchdog, far beyond the expected few thousand cycles
  initial
  begin
    #80000;
    error_cnt++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    @(negedge clk_sys_i);
    t_reset();
    t_init();
    t_write();
    t_read(1'b0);
    t_read(1'b1);
    t_fill();
    t_stall();
    check("panel faults", 8'h00, {7'h00, viol != 0});
    check("idle select", 8'h01, {7'h00, select_n});
    give_verdict();
  end
endmodule
